// ===== rtl/sram_core.sv
// Memory core: 64K words of 18 bits, per-lane write, flow-through read.
// Assumes write requests come from the port logic on the same clock.
`timescale 1ns/1ps
module sram_core
(
    // Clock and enable
    input wire logic clock,
    input wire logic clock_enable,
    // Write side
    input wire logic write_valid,
    input wire sram_port_pkg::core_write_t write_req,
    // Read side, combinational so data flows straight through
    input wire logic [sram_port_pkg::ADDR_W-1:0] read_addr,
    output logic [sram_port_pkg::DATA_W-1:0] read_data
);
    import sram_port_pkg::*;

    logic [DATA_W-1:0] mem [DEPTH];

    // Lane-wise write; each lane enable touches only its own 9 bits
    always_ff @(posedge clock)
    begin
        if (clock_enable && write_valid)
        begin
            for (int i = 0; i < LANES; i++)
            begin
                if (write_req.lane_en[i])
                    mem[write_req.addr][i*LANE_W +: LANE_W] <=
                        write_req.data[i*LANE_W +: LANE_W];
            end
        end
    end

    // Asynchronous read; the port registers the data afterwards
    assign read_data = mem[read_addr];
endmodule

// ===== rtl/sram_port.sv
// Port logic of a flow-through burst SRAM with common data I/O.
// Assumes pins arrive through the board; asynchronous ones are synchronised.
// Functional notes
// R1 - Burst step low during a burst advances to next burst address.
// R2 - Processor strobe low captures address and loads counter from bits 1:0.
// R3 - Controller strobe low captures address and loads counter from bits 1:0.
// R4 - Both strobes low: processor strobe acts, controller strobe ignored.
// R5 - Processor strobe ignored while chip select one is high.
// R6 - Sleep request high enters data-keeping sleep; held low normally.
// R7 - Reads drive data of location addressed at preceding clock rise.
// R8 - Output drive low drives data pins, high releases them.
// R9 - Strap low selects linear, high selects interleaved; strap static.
// R10 - Global write overrides byte selects and gate, writing every lane.
// R11 - Read starts with all selects active and either strobe low.
// R12 - Processor-strobe start ignores writes; next clock may write.
// R13 - Byte select A governs lane A only, B lane B only.
// R14 - Detected write releases data pins regardless of output drive.
// R15 - Host releases output drive before presenting write data.
// R16 - Controller-strobe start with write inputs writes in same cycle.
// R17 - Two-bit wraparound burst counter loaded from low address bits.
// R18 - Sleep entry and exit each take two clock cycles.
// R19 - Accesses pending on sleep entry are dropped.
// R20 - Host deselects the device before requesting sleep.
// R21 - Host keeps selects and strobes inactive during sleep recovery.
// R22 - Linear adds one modulo four; interleaved XORs start with count.
// R23 - No strobe and burst step high holds and repeats current address.
`timescale 1ns/1ps
module sram_port
(
    // Clock, reset and enable
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_enable,
    // Synchronous bus cycle inputs
    input wire sram_port_pkg::bus_cycle_t bus,
    // Asynchronous controls and strap
    input wire logic output_drive_n,
    input wire logic sleep_request,
    input wire logic burst_order_strap,
    // Data and parity pins, split into in, out and enable
    input wire logic [sram_port_pkg::DATA_W-1:0] data_in,
    output logic [sram_port_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    // Status
    output logic asleep
);
    import sram_port_pkg::*;

    // Next burst address in the chosen order
    function automatic logic [1:0] burst_next(input logic [1:0] start,
        input logic [1:0] count, input logic interleaved);
        logic [1:0] step;
        step = count + 2'h1;
        if (interleaved)
            burst_next = start ^ step; // [R22]
        else
            burst_next = start + step; // [R22]
    endfunction

    // Two-flop synchronisers for asynchronous pins
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic oe_n_s;
    logic sleep_s;
    logic strap_s;
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            // Idle pin levels: drive released, no sleep, strap pulled up
            sync1 <= 3'h5;
            sync2 <= 3'h5;
        end
        else if (clock_enable)
        begin
            sync1 <= {burst_order_strap, sleep_request, output_drive_n};
            sync2 <= sync1;
        end
    end
    assign oe_n_s = sync2[0];
    assign sleep_s = sync2[1];
    assign strap_s = sync2[2];

    // Input registers for the synchronous bus inputs
    bus_cycle_t bus_q;
    logic [DATA_W-1:0] din_q;
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            bus_q <= '1;
            bus_q.chip_sel2 <= 1'b0;
            bus_q.addr <= ADDR_RESET;
            din_q <= '0;
        end
        else if (clock_enable)
        begin
            bus_q <= bus;
            din_q <= data_in;
        end
    end

    // Sleep sequencer: two cycles in, two cycles out
    sleep_state_t sleep_state;
    sleep_state_t next_sleep_state;
    logic [1:0] sleep_cnt;
    logic [1:0] next_sleep_cnt;
    always_comb
    begin
        next_sleep_state = sleep_state;
        next_sleep_cnt = sleep_cnt;
        case (sleep_state)
            AWAKE:
                if (sleep_s)
                begin
                    next_sleep_state = ENTERING; // [R6]
                    next_sleep_cnt = 2'h1;
                end
            ENTERING:
                if (!sleep_s)
                    next_sleep_state = AWAKE;
                else if (sleep_cnt == SLEEP_ENTER_CYCLES - 2'h1)
                    next_sleep_state = ASLEEP; // [R18]
                else
                    next_sleep_cnt = sleep_cnt + 2'h1;
            ASLEEP:
                if (!sleep_s)
                begin
                    next_sleep_state = LEAVING;
                    next_sleep_cnt = 2'h1;
                end
            LEAVING:
                if (sleep_s)
                    next_sleep_state = ASLEEP;
                else if (sleep_cnt == SLEEP_EXIT_CYCLES - 2'h1)
                    next_sleep_state = AWAKE; // [R18]
                else
                    next_sleep_cnt = sleep_cnt + 2'h1;
            default:
                next_sleep_state = AWAKE;
        endcase
    end
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            sleep_state <= AWAKE;
            sleep_cnt <= 2'h0;
        end
        else if (clock_enable)
        begin
            sleep_state <= next_sleep_state;
            sleep_cnt <= next_sleep_cnt;
        end
    end
    logic awake;
    assign awake = (sleep_state == AWAKE);

    // Decode of the registered bus cycle
    logic selected;
    logic proc_start;
    logic ctrl_start;
    logic any_write;
    logic [LANES-1:0] lanes;
    assign selected = !bus_q.chip_sel1_n && bus_q.chip_sel2
        && !bus_q.chip_sel3_n; // [R11]
    // Processor strobe needs chip select one low in the same sampled cycle
    assign proc_start = !bus_q.processor_addr_strobe_n
        && !bus_q.chip_sel1_n; // [R5]
    assign ctrl_start = !bus_q.controller_addr_strobe_n
        && bus_q.processor_addr_strobe_n; // [R4]
    // Global write wins over byte gate and lane selects
    assign lanes = !bus_q.all_bytes_write_n ? {LANES{1'b1}} : // [R10]
        (bus_q.byte_write_gate_n ? '0 :
        {!bus_q.lane_b_write_sel_n, !bus_q.lane_a_write_sel_n}); // [R13]
    assign any_write = |lanes;

    // Access state: address register, burst counter, activity
    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] next_addr_reg;
    logic [1:0] burst_start;
    logic [1:0] next_burst_start;
    logic [1:0] burst_cnt;
    logic [1:0] next_burst_cnt;
    logic active;
    logic next_active;
    logic cycle_write;
    logic next_cycle_write;
    logic [1:0] cur_low;
    always_comb
    begin
        next_addr_reg = addr_reg;
        next_burst_start = burst_start;
        next_burst_cnt = burst_cnt;
        next_active = active;
        next_cycle_write = 1'b0;
        if (!awake)
            next_active = 1'b0; // [R19]
        else if (proc_start)
        begin
            // Writes ignored in the opening processor cycle
            next_active = selected; // [R12]
            next_addr_reg = bus_q.addr; // [R2]
            next_burst_start = bus_q.addr[BURST_MSB:BURST_LSB]; // [R2]
            next_burst_cnt = 2'h3;
        end
        else if (ctrl_start)
        begin
            next_active = selected;
            next_addr_reg = bus_q.addr; // [R3]
            next_burst_start = bus_q.addr[BURST_MSB:BURST_LSB]; // [R3]
            next_burst_cnt = 2'h3;
            next_cycle_write = selected && any_write; // [R16]
        end
        else if (active)
        begin
            if (!bus_q.burst_step_n)
                next_burst_cnt = burst_cnt + 2'h1; // [R1] [R17]
            // Step high: count holds, same location repeats
            next_cycle_write = any_write; // [R23] [R12]
        end
    end
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            addr_reg <= ADDR_RESET;
            burst_start <= BURST_RESET;
            burst_cnt <= BURST_RESET;
            active <= 1'b0;
            cycle_write <= 1'b0;
        end
        else if (clock_enable)
        begin
            addr_reg <= next_addr_reg;
            burst_start <= next_burst_start;
            burst_cnt <= next_burst_cnt;
            active <= next_active;
            cycle_write <= next_cycle_write;
        end
    end

    // Current low address bits in the strapped order
    assign cur_low = burst_next(burst_start, burst_cnt, strap_s); // [R9]

    // Memory core, written with data sampled with the write inputs
    logic [ADDR_W-1:0] core_addr;
    logic [DATA_W-1:0] core_rdata;
    logic core_we;
    core_write_t core_wr;
    // Address of this edge's access, including the new burst step; the
    // same address reads the core, so the word registered onto the
    // data pins at an edge is the one selected at that edge
    always_comb
    begin
        core_we = 1'b0;
        core_wr.lane_en = lanes;
        core_wr.data = din_q;
        core_wr.addr = {next_addr_reg[ADDR_W-1:BURST_MSB+1],
            burst_next(next_burst_start, next_burst_cnt, strap_s)};
        core_addr = core_wr.addr;
        if (awake && next_active)
            core_we = next_cycle_write; // [R16] [R12]
    end
    sram_core u_core
    (
        .clock(clock),
        .clock_enable(clock_enable),
        .write_valid(core_we),
        .write_req(core_wr),
        .read_addr(core_addr),
        .read_data(core_rdata)
    );

    // Registered pin drive; writes and sleep force release
    logic [DATA_W-1:0] next_data_out;
    logic next_data_oe;
    always_comb
    begin
        next_data_out = data_out;
        next_data_oe = 1'b0;
        if (awake && next_active && !next_cycle_write)
        begin
            next_data_out = core_rdata; // [R7]
            next_data_oe = !oe_n_s; // [R8]
        end
        if (next_cycle_write || any_write && active)
            next_data_oe = 1'b0; // [R14]
    end
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            data_out <= '0;
            data_oe <= 1'b0;
            asleep <= 1'b0;
        end
        else if (clock_enable)
        begin
            data_out <= next_data_out;
            data_oe <= next_data_oe;
            asleep <= (next_sleep_state == ASLEEP);
        end
    end

    // Checks
    a_write_release: assert property ( // [R14]
        @(posedge clock) disable iff (reset)
        clock_enable && next_cycle_write |=> !data_oe)
        else $error("data pins driven during write");
    a_oe_release: assert property ( // [R8]
        @(posedge clock) disable iff (reset)
        clock_enable && oe_n_s |=> !data_oe)
        else $error("data pins driven with output drive high");
    a_sleep_entry: assert property ( // [R18]
        @(posedge clock) disable iff (reset)
        sleep_state == AWAKE && sleep_s && clock_enable ##1 clock_enable
        && sleep_s ##1 clock_enable && sleep_s |-> sleep_state == ASLEEP)
        else $error("sleep entry not two cycles");
    a_sleep_exit: assert property ( // [R18]
        @(posedge clock) disable iff (reset)
        sleep_state == ASLEEP && !sleep_s && clock_enable ##1 clock_enable
        && !sleep_s ##1 clock_enable && !sleep_s |-> sleep_state == AWAKE)
        else $error("sleep exit not two cycles");
    a_sleep_drop: assert property ( // [R19]
        @(posedge clock) disable iff (reset)
        clock_enable && !awake |=> !active && !data_oe)
        else $error("access survived sleep");
    a_proc_load: assert property ( // [R2]
        @(posedge clock) disable iff (reset)
        clock_enable && awake && proc_start |=>
        addr_reg == $past(bus_q.addr) && cur_low == addr_reg[1:0]
        && !cycle_write)
        else $error("processor strobe load wrong");
    a_ctrl_ignored: assert property ( // [R4]
        @(posedge clock) disable iff (reset)
        clock_enable && awake && proc_start
        && !bus_q.controller_addr_strobe_n |=> !cycle_write)
        else $error("controller strobe acted with processor strobe");
    a_burst_step: assert property ( // [R1]
        @(posedge clock) disable iff (reset)
        clock_enable && awake && active && !proc_start && !ctrl_start
        && !bus_q.burst_step_n |=> burst_cnt == $past(burst_cnt) + 2'h1)
        else $error("burst did not advance");
    a_burst_hold: assert property ( // [R23]
        @(posedge clock) disable iff (reset)
        clock_enable && awake && active && !proc_start && !ctrl_start
        && bus_q.burst_step_n |=> $stable(burst_cnt))
        else $error("burst moved while suspended");
    a_global_write: assert property ( // [R10]
        @(posedge clock) disable iff (reset)
        !bus_q.all_bytes_write_n |-> lanes == 2'h3)
        else $error("global write missed a lane");
endmodule

// ===== rtl/sram_port_pkg.sv
// Constants and carrier types for the flow-through synchronous SRAM port.
// Assumes a single clock domain; shared by the port and its memory core.
package sram_port_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 18;
    localparam int LANE_W = 9;
    localparam int LANES = 2;
    localparam int DEPTH = 65536;
    // Low address bits that feed the burst counter
    localparam int BURST_LSB = 0;
    localparam int BURST_MSB = 1;
    // Sleep entry and exit latency in clock cycles
    localparam logic [1:0] SLEEP_ENTER_CYCLES = 2'h2;
    localparam logic [1:0] SLEEP_EXIT_CYCLES = 2'h2;
    // Reset values of control state
    localparam logic [1:0] BURST_RESET = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 16'h0000;

    // Bus cycle inputs sampled at the rising edge
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic burst_step_n;
        logic chip_sel1_n;
        logic chip_sel2;
        logic chip_sel3_n;
        logic all_bytes_write_n;
        logic byte_write_gate_n;
        logic lane_a_write_sel_n;
        logic lane_b_write_sel_n;
    } bus_cycle_t;

    // Write request to the memory core
    typedef struct packed {
        logic [LANES-1:0] lane_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } core_write_t;

    // Sleep sequencing states
    typedef enum logic [3:0] {
        AWAKE = 4'b0001,
        ENTERING = 4'b0010,
        ASLEEP = 4'b0100,
        LEAVING = 4'b1000
    } sleep_state_t;
endpackage

// ===== sim/flow_through_sync_sram_port_bench.sv
// Self-checking bench for the flow-through SRAM port.
// Assumes the host model makes every bus cycle; bench resolves the pins.
`timescale 1ns/1ps
module flow_through_sync_sram_port_bench;
    import sram_port_pkg::*;
    typedef struct packed {
        logic [15:0] addr;
        logic [17:0] data;
        logic [3:0] wr;
        logic [17:0] exp;
    } row_t;

    // Clock, reset and wiring
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clock_enable = 1'b1;
    bus_cycle_t bus;
    logic output_drive_n, sleep_request, burst_order_strap;
    logic [DATA_W-1:0] data_in, data_out, host_data, pins;
    logic [DATA_W-1:0] last_pins = '0;
    logic data_oe, asleep, host_oe;
    int n_mismatch = 0;
    int tests_run = 0;
    // Write over 15555, wr is all-bytes, gate, lane A, lane B
    row_t rows [0:6] = '{
        '{16'h0010, 18'h2aaaa, 4'h7, 18'h2aaaa},
        '{16'h0011, 18'h2aaaa, 4'h0, 18'h2aaaa},
        '{16'h0012, 18'h2aaaa, 4'h9, 18'h154aa},
        '{16'h0013, 18'h2aaaa, 4'ha, 18'h2ab55},
        '{16'h0014, 18'h2aaaa, 4'h8, 18'h2aaaa},
        '{16'h0015, 18'h2aaaa, 4'hc, 18'h15555},
        '{16'h0016, 18'h2aaaa, 4'hb, 18'h15555}};

    always #50 clock = ~clock;

    // Floating pins show the inverse of the last level, not a held value
    assign pins = (data_oe === 1'b1) ? data_out :
        (host_oe ? host_data : ~last_pins);
    assign data_in = pins;
    always @(posedge clock) last_pins <= pins;

    sram_port i_dut (.clock(clock), .reset(reset),
        .clock_enable(clock_enable), .bus(bus),
        .output_drive_n(output_drive_n), .sleep_request(sleep_request),
        .burst_order_strap(burst_order_strap), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .asleep(asleep));
    sram_host_model i_host (.clock(clock), .pins(pins),
        .data_oe(data_oe), .bus(bus), .output_drive_n(output_drive_n),
        .sleep_request(sleep_request),
        .burst_order_strap(burst_order_strap), .host_data(host_data),
        .host_oe(host_oe));

    // Compare tasks
    task automatic check_data(input logic [DATA_W-1:0] got,
        input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Eight cycles of reset; outputs must be quiet meanwhile
    task automatic do_reset();
        reset = 1'b1;
        repeat (8) i_host.step();
        check_data(data_out, '0);
        check_flag(data_oe, 1'b0);
        check_flag(asleep, 1'b0);
        reset = 1'b0;
    endtask

    // Main sequence
    initial
    begin
        bus_cycle_t b;
        int e;
        do_reset();
        // Table of writes over a known word, read back by either strobe
        foreach (rows[i])
        begin
            i_host.write(rows[i].addr, 18'h15555, 4'h7);
            i_host.write(rows[i].addr, rows[i].data, rows[i].wr);
            i_host.read(rows[i].addr, i[0]);
            check_flag(data_oe, 1'b1);
            check_data(pins, rows[i].exp);
        end
        i_host.release_pins();
        check_flag(data_oe, 1'b0);
        // Both strobes low with writes on: a read, nothing written
        b = i_host.mk(16'h0012, 4'b0010, 4'h0);
        i_host.cycle(b, 18'h3ffff, 1'b1);
        i_host.idle(4);
        i_host.read(16'h0012, 1'b0);
        check_data(pins, 18'h154aa);
        // Writes ignored at a processor start, taken one cycle later
        i_host.release_pins();
        b = i_host.mk(16'h0013, 4'b0110, 4'h0);
        i_host.cycle(b, 18'h3ffff, 1'b1);
        b = i_host.mk(16'h0013, 4'b1111, 4'h0);
        i_host.cycle(b, 18'h0f0f0, 1'b1);
        i_host.idle(2);
        i_host.read(16'h0013, 1'b0);
        check_data(pins, 18'h0f0f0);
        // Processor strobe with select one high changes nothing
        b = i_host.mk(16'h0010, 4'b0111, 4'hf);
        i_host.cycle(b, '0, 1'b0);
        i_host.idle(4);
        check_data(pins, 18'h0f0f0);
        // Enable low freezes all state, so this burst step is lost
        clock_enable = 1'b0;
        b = i_host.mk(16'h0000, 4'b1101, 4'hf);
        i_host.cycle(b, '0, 1'b0);
        i_host.idle(2);
        clock_enable = 1'b1;
        i_host.idle(4);
        check_data(pins, 18'h0f0f0);
        // Processor strobe with select two low deselects
        b = i_host.mk(16'h0010, 4'b0110, 4'hf);
        b.chip_sel2 = 1'b0;
        i_host.cycle(b, '0, 1'b0);
        i_host.idle(4);
        check_flag(data_oe, 1'b0);
        // Controller strobe with select three off deselects
        b = i_host.mk(16'h0010, 4'b1010, 4'hf);
        b.chip_sel3_n = 1'b1;
        i_host.cycle(b, '0, 1'b0);
        i_host.idle(4);
        check_flag(data_oe, 1'b0);
        // Sleep keeps data and drops an access made while asleep
        i_host.write(16'h0030, 18'h1c3c3, 4'h7);
        i_host.set_sleep(1'b1);
        i_host.idle(1);
        check_flag(asleep, 1'b0);
        for (e = 0; e < 10 && asleep !== 1'b1; e++)
            i_host.idle(1);
        check_flag(asleep, 1'b1);
        i_host.write(16'h0030, 18'h00fff, 4'h7);
        i_host.set_sleep(1'b0);
        i_host.idle(1);
        check_flag(asleep, 1'b1);
        for (e = 0; e < 10 && asleep !== 1'b0; e++)
            i_host.idle(1);
        check_flag(asleep, 1'b0);
        i_host.idle(4);
        i_host.read(16'h0030, 1'b1);
        check_data(pins, 18'h1c3c3);
        // Burst words 0a000 plus offset, at an aligned base
        for (int k = 0; k < 4; k++)
            i_host.write({14'h0008, k[1:0]}, {16'h2800, k[1:0]}, 4'h7);
        // Both orders, every start, four steps to prove the wrap
        for (int m = 0; m < 2; m++)
        begin
            reset = 1'b1;
            i_host.set_strap(m[0]);
            do_reset();
            for (int s = 0; s < 4; s++)
            begin
                i_host.read({14'h0008, s[1:0]}, s[0]);
                check_data(pins, {16'h2800, s[1:0]});
                for (int k = 1; k <= 4; k++)
                begin
                    b = i_host.mk(16'h0000, 4'b1101, 4'hf);
                    i_host.cycle(b, '0, 1'b0);
                    i_host.idle(4);
                    e = m ? ((s ^ k) & 3) : ((s + k) & 3);
                    check_data(pins, {16'h2800, e[1:0]});
                end
            end
        end
        summarize();
    end

    // Watchdog: the run needs under 1500 cycles
    initial
    begin
        #1000000;
        n_mismatch++;
        summarize();
    end
endmodule

// ===== sim/sram_host_model.sv
// Host side model: drives bus cycles, output drive, sleep and strap.
// Assumes the bench resolves the shared data pins into pins.
`timescale 1ns/1ps
module sram_host_model
(
    // Clock and board view of the pins
    input wire logic clock,
    input wire logic [sram_port_pkg::DATA_W-1:0] pins,
    input wire logic data_oe,
    // Toward the device
    output sram_port_pkg::bus_cycle_t bus,
    output logic output_drive_n,
    output logic sleep_request,
    output logic burst_order_strap,
    output logic [sram_port_pkg::DATA_W-1:0] host_data,
    output logic host_oe
);
    import sram_port_pkg::*;

    // Cycle with selects two and three on; ctl is strobes, step, select one
    function automatic bus_cycle_t mk(input logic [ADDR_W-1:0] a,
        input logic [3:0] ctl, input logic [3:0] wr);
        mk = '{a, ctl[3], ctl[2], ctl[1], ctl[0], 1'b1, 1'b0,
            wr[3], wr[2], wr[1], wr[0]};
    endfunction

    // Quiet start; sleep low for normal work, strap fixed
    initial
    begin
        bus = mk(16'h0000, 4'hf, 4'hf);
        output_drive_n = 1'b1;
        sleep_request = 1'b0;
        burst_order_strap = 1'b0;
        host_data = '0;
        host_oe = 1'b0;
    end

    // Inputs move a fixed delay after the rising edge
    task automatic step();
        @(posedge clock);
        #10;
    endtask

    // Strobes high, select one off, pins released by the host
    task automatic idle(input int n);
        bus = mk(16'h0000, 4'hf, 4'hf);
        host_oe = 1'b0;
        repeat (n) step();
    endtask

    // One bus cycle held across its sampling edge
    task automatic cycle(input bus_cycle_t b,
        input logic [DATA_W-1:0] d, input logic d_en);
        bus = b;
        host_data = d;
        host_oe = d_en;
        step();
    endtask

    // Avoids contention: device must float before host drives
    task automatic release_pins();
        output_drive_n = 1'b1;
        for (int i = 0; i < 8 && data_oe !== 1'b0; i++)
            step();
    endtask

    // Controller strobe write, data at the same edge
    task automatic write(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [3:0] wr);
        release_pins();
        cycle(mk(a, 4'b1010, wr), d, 1'b1);
        idle(2);
    endtask

    // Read start; write inputs kept off even on a controller start
    task automatic read(input logic [ADDR_W-1:0] a, input logic ctrl);
        output_drive_n = 1'b0;
        cycle(mk(a, {ctrl, !ctrl, 2'b10}, 4'hf), '0, 1'b0);
        idle(4);
    endtask

    // Deselect before asking for sleep
    task automatic set_sleep(input logic v);
        if (v)
        begin
            cycle(mk(16'h0000, 4'b1011, 4'hf), '0, 1'b0);
            idle(1);
        end
        sleep_request = v;
    endtask

    // Only called while the bench holds reset
    task automatic set_strap(input logic v);
        burst_order_strap = v;
    endtask
endmodule
